// ### grfp_pkg.sv
// Constants and types for the graphics rail fault-protection block
package grfp_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int OV_FILT_NS    = 1000;
    localparam int NV_FILT_NS    = 1000;
    localparam int UV_FILT_NS    = 3000;
    localparam int LO_FILT_NS    = 3000;
    // Least times round up to whole cycles
    localparam int OV_FILT_CYC = (OV_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NV_FILT_CYC = (NV_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UV_FILT_CYC = (UV_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LO_FILT_CYC = (LO_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLT_CNT_W   = 8;
    localparam int NUM_FLT     = 4;

    // Voltage thresholds in millivolts
    localparam int MV_W          = 14;
    localparam int OV_MARGIN_MV  = 150;
    localparam int OV_OFFSET_MV  = 850;
    localparam int OFS_HIGH_MV   = 900;
    localparam int OFS_GND_MV    = 50;
    localparam int NV_TRIP_MV    = -50;
    localparam int NV_CLEAR_MV   = 0;
    localparam int UV_MARGIN_MV  = 300;

    // Filter channel indices
    localparam int F_OV = 0;
    localparam int F_NV = 1;
    localparam int F_UV = 2;
    localparam int F_LO = 3;

    // Register byte offsets
    localparam logic [7:0] A_VIDMAX = 8'h00;
    localparam logic [7:0] A_REF    = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h08;
    localparam logic [7:0] A_MASK   = 8'h0C;
    localparam logic [7:0] A_STATE  = 8'h10;
    localparam logic [11:0] VIDMAX_RST = 12'h5F0;
    localparam logic [11:0] REF_RST    = 12'h000;
    localparam logic [3:0]  MASK_RST   = 4'h0;

    // Event bit positions in status and mask
    localparam int EV_OV = 0;
    localparam int EV_NV = 1;
    localparam int EV_UV = 2;
    localparam int EV_LO = 3;

    // Gate command states, one-hot
    typedef enum logic [4:0] {
        ST_RUN  = 5'b00001,
        ST_OVLO = 5'b00010,
        ST_NVOF = 5'b00100,
        ST_UVOF = 5'b01000,
        ST_LOCK = 5'b10000
    } grfp_state_t;

endpackage

// ### grfp_top.sv
// Graphics rail fault protection: filters, latches, gate control, Wishbone regs
//
// Function
// - Over-voltage monitoring begins after power-on reset
// - Latch over-voltage above max VID plus 150mV
// - Over-voltage latch: low-side on, high-side off
// - Over-voltage also requests core rail shutdown
// - Over-voltage condition must persist 1us
// - Offset above 0.9V at power-up: 850mV margin
// - Negative-voltage check only during over-voltage latch
// - Below -0.05V: all switches off
// - Above 0V again: low-side back on
// - Negative-voltage condition filtered for 1us
// - Latch under-voltage at 300mV below reference
// - Under-voltage latch holds all switches off
// - Under-voltage also requests core soft shutdown
// - Under-voltage condition filtered for 3us
// - Offset input not grounded disables under-voltage
// - Supply below threshold raises lockout fault
// - Lockout tri-states the switching driver
// - Supply-low condition filtered for 3us
module grfp_top
    import grfp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               clkEn,
    // Analog sense results, signed millivolts
    input  wire logic signed [13:0] gfxOutputSenseNeg,
    input  wire logic signed [13:0] gfxFeedbackInput,
    input  wire logic signed [13:0] gfxOffsetSetInput,
    // Supply comparators, high while above threshold
    input  wire logic               controllerSupplyOk,
    input  wire logic               driverSupplySense,
    // Modulator gate requests
    input  wire logic               pwmHighReq,
    input  wire logic               pwmLowReq,
    // Power stage commands
    output logic                    highSideOn,
    output logic                    lowSideOn,
    output logic                    driverHiZ,
    output logic                    coreRailShutdown,
    // Wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o,
    // Interrupt
    output logic                    irq
);

    // Merge a write into a 12-bit field by byte lane
    function automatic logic [11:0] laneMerge(
        input logic [11:0] old,
        input logic [31:0] wdat,
        input logic [3:0]  sel
    );
        logic [11:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            res[11:8] = wdat[11:8];
        end
        return res;
    endfunction

    // Filter lengths per channel
    localparam int FLEN [NUM_FLT] = '{OV_FILT_CYC, NV_FILT_CYC, UV_FILT_CYC, LO_FILT_CYC};

    // Power-on reset completion flag
    logic                porDone;
    // Offset straps captured at power-up
    logic                offsetHigh;
    logic                offsetEn;
    // Software registers
    logic [11:0]         maxOperatingVidStore;
    logic [11:0]         refLevel;
    logic [3:0]          status;
    logic [3:0]          mask;
    // Fault latches, plus the unlatched supply lockout flag
    logic                overVoltageFault;
    logic                negativeVoltageFault;
    logic                underVoltageFault;
    logic                supplyLockoutFault;
    // Raw and filtered comparator conditions
    logic [NUM_FLT-1:0]  rawCond;
    logic [NUM_FLT-1:0]  fltCond;
    // Computed thresholds
    logic signed [MV_W-1:0] ovThresh;
    logic signed [MV_W-1:0] uvThresh;
    // Event pulses into status
    logic [3:0]          events;
    logic                lockoutPrev;
    // Bus decode
    logic                busReq;
    logic                busWr;
    logic [3:0]          w1c;
    // Gate state
    grfp_state_t         state;
    grfp_state_t         next_state;

    // Power-on reset done one enabled cycle after release
    // monitoring gate
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            porDone <= 1'b0;
        end else if (clkEn) begin
            porDone <= 1'b1;
        end
    end

    // Capture offset straps once, at the first cycle after release
    // A reset value can only be a constant, so the pin is sampled here
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            offsetHigh <= 1'b0;
            offsetEn   <= 1'b0;
        end else if (clkEn && !porDone) begin
            offsetHigh <= (gfxOffsetSetInput > MV_W'(OFS_HIGH_MV));
            offsetEn   <= (gfxOffsetSetInput > MV_W'(OFS_GND_MV));
        end
    end

    // Thresholds from stored max VID and reference
    always_comb begin
        ovThresh = $signed({2'b00, maxOperatingVidStore}) + MV_W'(OV_MARGIN_MV);
        if (offsetHigh) begin
            ovThresh = $signed({2'b00, maxOperatingVidStore}) + MV_W'(OV_OFFSET_MV);
        end
        uvThresh = $signed({2'b00, refLevel}) - MV_W'(UV_MARGIN_MV);
    end

    // Raw comparator conditions
    always_comb begin
        rawCond[F_OV] = porDone && (gfxOutputSenseNeg > ovThresh);
        // negative check only under over-voltage latch
        rawCond[F_NV] = overVoltageFault && (gfxOutputSenseNeg < MV_W'(NV_TRIP_MV));
        // feedback at or below threshold; disables it
        rawCond[F_UV] = porDone && !offsetEn && (gfxFeedbackInput <= uvThresh);
        rawCond[F_LO] = porDone && !(controllerSupplyOk && driverSupplySense);
    end

    // Deglitch filters: condition must hold a full window
    // Any gap restarts the count, so short spikes never trip
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLT; gi++) begin : gFlt
            logic [FLT_CNT_W-1:0] cnt;
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    cnt <= '0;
                end else if (clkEn) begin
                    if (!rawCond[gi]) begin
                        cnt <= '0;
                    end else if (cnt != FLT_CNT_W'(FLEN[gi])) begin
                        cnt <= cnt + 1'b1;
                    end
                end
            end
            assign fltCond[gi] = rawCond[gi] && (cnt == FLT_CNT_W'(FLEN[gi]));
        end
    endgenerate

    // Over-voltage latch
    // released only by reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            overVoltageFault <= 1'b0;
        end else if (clkEn && fltCond[F_OV]) begin
            overVoltageFault <= 1'b1;
        end
    end

    // Negative-voltage trip, live only under over-voltage latch
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            negativeVoltageFault <= 1'b0;
        end else if (clkEn) begin
            if (fltCond[F_NV]) begin
                negativeVoltageFault <= 1'b1;
            end else if (gfxOutputSenseNeg > MV_W'(NV_CLEAR_MV)) begin
                negativeVoltageFault <= 1'b0;
            end
        end
    end

    // Under-voltage latch
    // released only by reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            underVoltageFault <= 1'b0;
        end else if (clkEn && fltCond[F_UV]) begin
            underVoltageFault <= 1'b1;
        end
    end

    // Supply lockout follows the filtered supply state
    // Not latched: it lifts once both supplies are back
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            supplyLockoutFault <= 1'b0;
        end else if (clkEn) begin
            supplyLockoutFault <= fltCond[F_LO];
        end
    end

    // Gate state selection, lockout first, then under-voltage
    always_comb begin
        next_state = ST_RUN;
        if (supplyLockoutFault) begin
            next_state = ST_LOCK;
        end else if (underVoltageFault) begin
            next_state = ST_UVOF;
        end else if (overVoltageFault && negativeVoltageFault) begin
            next_state = ST_NVOF;
        end else if (overVoltageFault) begin
            next_state = ST_OVLO;
        end
    end

    // Gate state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_LOCK;
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    // Registered gate commands; driver stays off until reset ends
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            highSideOn <= 1'b0;
            lowSideOn  <= 1'b0;
            driverHiZ  <= 1'b1;
        end else if (clkEn) begin
            unique case (next_state)
                // Normal switching passes the modulator through
                ST_RUN: begin
                    highSideOn <= pwmHighReq;
                    lowSideOn  <= pwmLowReq && !pwmHighReq;
                    driverHiZ  <= 1'b0;
                end
                ST_OVLO: begin
                    highSideOn <= 1'b0;
                    lowSideOn  <= 1'b1;
                    driverHiZ  <= 1'b0;
                end
                ST_NVOF: begin
                    highSideOn <= 1'b0;
                    lowSideOn  <= 1'b0;
                    driverHiZ  <= 1'b0;
                end
                ST_UVOF: begin
                    highSideOn <= 1'b0;
                    lowSideOn  <= 1'b0;
                    driverHiZ  <= 1'b0;
                end
                ST_LOCK: begin
                    highSideOn <= 1'b0;
                    lowSideOn  <= 1'b0;
                    driverHiZ  <= 1'b1;
                end
            endcase
        end
    end

    // Core rail shutdown request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            coreRailShutdown <= 1'b0;
        end else if (clkEn) begin
            // either latch shuts the core down
            coreRailShutdown <= overVoltageFault || underVoltageFault;
        end
    end

    // Event pulses: the cycle each condition first latches
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lockoutPrev <= 1'b0;
        end else if (clkEn) begin
            lockoutPrev <= fltCond[F_LO];
        end
    end

    always_comb begin
        events        = '0;
        events[EV_OV] = fltCond[F_OV] && !overVoltageFault;
        events[EV_NV] = fltCond[F_NV] && !negativeVoltageFault;
        events[EV_UV] = fltCond[F_UV] && !underVoltageFault;
        events[EV_LO] = fltCond[F_LO] && !lockoutPrev;
    end

    // Bus decode; a write lands on the edge where ack is seen
    assign busReq = wb_cyc_i && wb_stb_i;
    assign busWr  = busReq && wb_we_i && wb_ack_o;
    assign w1c    = (busWr && wb_adr_i == A_STATUS && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

    // Single-wait acknowledge, dropped the cycle after
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else if (clkEn) begin
            wb_ack_o <= busReq && !wb_ack_o;
        end
    end

    // Read data captured as ack rises; unmapped reads zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (clkEn && busReq && !wb_ack_o) begin
            unique case (wb_adr_i)
                A_VIDMAX: wb_dat_o <= {20'h00000, maxOperatingVidStore};
                A_REF:    wb_dat_o <= {20'h00000, refLevel};
                A_STATUS: wb_dat_o <= {28'h0000000, status};
                A_MASK:   wb_dat_o <= {28'h0000000, mask};
                A_STATE:  wb_dat_o <= {21'h000000, state, offsetEn, offsetHigh,
                                       supplyLockoutFault, underVoltageFault,
                                       negativeVoltageFault, overVoltageFault};
                default:  wb_dat_o <= '0;
            endcase
        end
    end

    // Max VID and reference registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            maxOperatingVidStore <= VIDMAX_RST;
            refLevel             <= REF_RST;
        end else if (clkEn && busWr) begin
            if (wb_adr_i == A_VIDMAX) begin
                maxOperatingVidStore <= laneMerge(maxOperatingVidStore, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == A_REF) begin
                refLevel <= laneMerge(refLevel, wb_dat_i, wb_sel_i);
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask <= MASK_RST;
        end else if (clkEn && busWr && wb_adr_i == A_MASK && wb_sel_i[0]) begin
            mask <= wb_dat_i[3:0];
        end
    end

    // Sticky status; a new event beats a same-cycle clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status <= '0;
        end else if (clkEn) begin
            status <= (status & ~w1c) | events;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else if (clkEn) begin
            irq <= |(((status & ~w1c) | events) & mask);
        end
    end

endmodule

// ### grfp_top_sva.sv
// Port-level assertion checker for the graphics rail fault-protection block
module grfp_chk
    import grfp_pkg::*;
(
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               rst,
    // Watched inputs
    input wire logic signed [13:0] gfxOutputSenseNeg,
    input wire logic signed [13:0] gfxOffsetSetInput,
    input wire logic               controllerSupplyOk,
    input wire logic               driverSupplySense,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    // Watched outputs
    input wire logic               highSideOn,
    input wire logic               lowSideOn,
    input wire logic               driverHiZ,
    input wire logic               coreRailShutdown,
    input wire logic               wb_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       started; // First cycle after reset seen
    logic       ofsHigh; // Offset strap read high at power-up
    logic [7:0] ovCnt;   // Cycles with sense above trip level
    logic [7:0] loCnt;   // Cycles with a supply low
    int         tripMv;  // Active over-voltage trip level

    assign tripMv = ofsHigh ? int'(VIDMAX_RST) + OV_OFFSET_MV : int'(VIDMAX_RST) + OV_MARGIN_MV;

    // Strap copy; only the reset-value maximum VID is modelled here
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            started <= 1'b0;
            ofsHigh <= 1'b0;
        end else if (!started) begin
            started <= 1'b1;
            ofsHigh <= (gfxOffsetSetInput > OFS_HIGH_MV);
        end
    end

    // Saturating run-length counters of the raw conditions
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ovCnt <= 8'h00;
            loCnt <= 8'h00;
        end else begin
            ovCnt <= (gfxOutputSenseNeg <= tripMv) ? 8'h00 : ovCnt + {7'h00, ovCnt != 8'hFF};
            loCnt <= (controllerSupplyOk && driverSupplySense) ? 8'h00 : loCnt + {7'h00, loCnt != 8'hFF};
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_no_overlap: assert property (!(highSideOn && lowSideOn))
        else $error("both switches on");
    a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_lock_filter: assert property (loCnt >= 8'd124 |-> driverHiZ)
        else $error("lockout missed");
    a_lock_early: assert property ($rose(driverHiZ) |-> loCnt >= 8'd118)
        else $error("lockout before filter");
    a_hiz_all_off: assert property (driverHiZ |-> !highSideOn && !lowSideOn)
        else $error("switch on while tri-stated");
    a_fault_sticky: assert property (coreRailShutdown |=> coreRailShutdown)
        else $error("fault latch released");
    a_ov_filter: assert property (ovCnt >= 8'd45 |-> coreRailShutdown && lowSideOn && !highSideOn)
        else $error("over-voltage response missing");
    a_fault_high_off: assert property (coreRailShutdown |-> !highSideOn)
        else $error("high side on under fault");

    c_ov_trip: cover property ($rose(coreRailShutdown));
    c_lockout: cover property ($rose(driverHiZ));
    c_bus_write: cover property (wb_ack_o && wb_we_i);
endmodule

// ### grfp_stage_model.sv
// Power-stage driver model facing the gate commands
module grfp_stage_model
    import grfp_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst,
    // Bench controls of the stage
    input  wire logic signed [13:0] levelMv,
    input  wire logic               supplyUp,
    // Gate commands
    input  wire logic               highSideOn,
    input  wire logic               lowSideOn,
    input  wire logic               driverHiZ,
    // Back to the controller
    output logic signed [13:0]      senseMv,
    output logic                    supplyOk,
    output logic                    overlapSeen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Ideal sense node; a real stage lags, which only eases the filters
    assign senseMv = levelMv;
    // Driver supply comparator of the stage
    assign supplyOk = supplyUp;

    // Both switches on shorts the input; remembered until reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) overlapSeen <= 1'b0;
        else if (highSideOn && lowSideOn && !driverHiZ) overlapSeen <= 1'b1;
    end
endmodule

// ### tb_graphics_rail_fault_protection.sv
// Self-checking testbench for the graphics rail fault-protection block
module tb_graphics_rail_fault_protection;
    timeunit 1ns;
    timeprecision 1ps;
    import grfp_pkg::*;

    logic               sys_clk, rst, supOk, drvOk, pwmHighReq, pwmLowReq, clkEn;
    logic signed [13:0] level, fb, ofs, sense;
    logic               drvSense, highSideOn, lowSideOn, driverHiZ, coreRailShutdown, irq, overlapSeen;
    logic               wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]         wb_adr_i;
    logic [3:0]         wb_sel_i;
    logic [31:0]        wb_dat_i, wb_dat_o, rd;
    int                 num_errors, num_checks, cycles;

    grfp_stage_model stage_u (.sys_clk(sys_clk), .rst(rst), .levelMv(level), .supplyUp(drvOk),
        .highSideOn(highSideOn), .lowSideOn(lowSideOn), .driverHiZ(driverHiZ), .senseMv(sense),
        .supplyOk(drvSense), .overlapSeen(overlapSeen));

    grfp_top dut_u (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .gfxOutputSenseNeg(sense),
        .gfxFeedbackInput(fb), .gfxOffsetSetInput(ofs), .controllerSupplyOk(supOk),
        .driverSupplySense(drvSense), .pwmHighReq(pwmHighReq), .pwmLowReq(pwmLowReq),
        .highSideOn(highSideOn), .lowSideOn(lowSideOn), .driverHiZ(driverHiZ),
        .coreRailShutdown(coreRailShutdown), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq(irq));

    // Clock at 40 MHz
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Hang guard, far above the expected run length
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %b got %b", nm, exp, got);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // One classic cycle; waits for ack and checks that it comes on the second edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        chk_word("ack wait", 32'd2, n);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Power-on reset with a chosen offset strap level
    task automatic do_reset(input logic signed [13:0] ofsMv);
        rst <= 1'b1;
        ofs <= ofsMv;
        tick(4);
        rst <= 1'b0;
        tick(2);
    endtask

    task automatic t_regs();
        wb_xfer(1'b0, A_VIDMAX, 4'hF, 32'h0);
        chk_word("vidmax", {20'h0, VIDMAX_RST}, rd);
        wb_xfer(1'b0, A_MASK, 4'hF, 32'h0);
        chk_word("mask", {28'h0, MASK_RST}, rd);
        wb_xfer(1'b1, 8'h20, 4'hF, 32'hFFFFFFFF);
        wb_xfer(1'b0, 8'h20, 4'hF, 32'h0);
        chk_word("unmapped", 32'h0, rd);
        // Low byte lane only
        wb_xfer(1'b1, A_VIDMAX, 4'h1, 32'h00000ABC);
        wb_xfer(1'b0, A_VIDMAX, 4'hF, 32'h0);
        chk_word("vidmax lane", 32'h000005BC, rd);
        wb_xfer(1'b1, A_VIDMAX, 4'hF, {20'h0, VIDMAX_RST});
    endtask

    task automatic t_lock();
        supOk <= 1'b0;
        tick(60);
        chk_bit("driverHiZ", 1'b0, driverHiZ);
        tick(70);
        chk_bit("driverHiZ", 1'b1, driverHiZ);
        chk_bit("highSideOn", 1'b0, highSideOn);
        chk_bit("irq", 1'b0, irq);
        wb_xfer(1'b0, A_STATUS, 4'hF, 32'h0);
        chk_word("status", 32'h8, rd & 32'hF);
        supOk <= 1'b1;
        tick(4);
        chk_bit("driverHiZ", 1'b0, driverHiZ);
        wb_xfer(1'b1, A_MASK, 4'hF, 32'h8);
        tick(2);
        chk_bit("irq", 1'b1, irq);
        wb_xfer(1'b1, A_STATUS, 4'hF, 32'h8);
        tick(2);
        chk_bit("irq", 1'b0, irq);
        drvOk <= 1'b0;
        tick(130);
        chk_bit("driverHiZ", 1'b1, driverHiZ);
        chk_bit("lowSideOn", 1'b0, lowSideOn);
        chk_bit("irq", 1'b1, irq);
        drvOk <= 1'b1;
        tick(4);
        wb_xfer(1'b1, A_STATUS, 4'hF, 32'hF);
    endtask

    task automatic t_ov();
        level <= -14'sd100;
        tick(60);
        chk_bit("lowSideOn", 1'b1, lowSideOn);
        pwmHighReq <= 1'b1;
        pwmLowReq  <= 1'b0;
        level <= 14'sd1671;
        tick(30);
        level <= 14'sd1670;
        tick(60);
        chk_bit("coreRailShutdown", 1'b0, coreRailShutdown);
        level <= 14'sd1671;
        tick(46);
        chk_bit("lowSideOn", 1'b1, lowSideOn);
        chk_bit("highSideOn", 1'b0, highSideOn);
        chk_bit("coreRailShutdown", 1'b1, coreRailShutdown);
        level <= -14'sd50;
        tick(60);
        chk_bit("lowSideOn", 1'b1, lowSideOn);
        level <= -14'sd51;
        tick(30);
        chk_bit("lowSideOn", 1'b1, lowSideOn);
        tick(16);
        chk_bit("lowSideOn", 1'b0, lowSideOn);
        level <= 14'sd0;
        tick(10);
        chk_bit("lowSideOn", 1'b0, lowSideOn);
        level <= 14'sd1;
        tick(4);
        chk_bit("lowSideOn", 1'b1, lowSideOn);
        level <= 14'sd1000;
        tick(100);
        chk_bit("coreRailShutdown", 1'b1, coreRailShutdown);
        do_reset(14'sd0);
        chk_bit("coreRailShutdown", 1'b0, coreRailShutdown);
    endtask

    task automatic t_uv();
        wb_xfer(1'b1, A_REF, 4'hF, 32'h3E8);
        fb <= 14'sd701;
        tick(150);
        chk_bit("coreRailShutdown", 1'b0, coreRailShutdown);
        fb <= 14'sd700;
        tick(100);
        chk_bit("coreRailShutdown", 1'b0, coreRailShutdown);
        tick(30);
        chk_bit("coreRailShutdown", 1'b1, coreRailShutdown);
        chk_bit("highSideOn", 1'b0, highSideOn);
        chk_bit("lowSideOn", 1'b0, lowSideOn);
        fb <= 14'sd1000;
        do_reset(14'sd901);
        // Offset strap high: no under-voltage, wider over-voltage margin
        fb <= -14'sd1000;
        tick(150);
        chk_bit("coreRailShutdown", 1'b0, coreRailShutdown);
        level <= 14'sd2370;
        tick(60);
        chk_bit("coreRailShutdown", 1'b0, coreRailShutdown);
        level <= 14'sd2371;
        tick(46);
        chk_bit("coreRailShutdown", 1'b1, coreRailShutdown);
        chk_bit("lowSideOn", 1'b1, lowSideOn);
        fb <= 14'sd1000;
        level <= 14'sd1000;
        do_reset(14'sd0);
    endtask

    initial begin
        rst <= 1'b1;
        clkEn <= 1'b1;
        supOk <= 1'b1;
        drvOk <= 1'b1;
        pwmHighReq <= 1'b0;
        pwmLowReq <= 1'b1;
        level <= 14'sd1000;
        fb <= 14'sd1000;
        ofs <= 14'sd0;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_adr_i <= 8'h00;
        wb_sel_i <= 4'hF;
        wb_dat_i <= 32'h0;
        num_errors = 0;
        num_checks = 0;
        cycles = 0;
        do_reset(14'sd0);
        chk_bit("driverHiZ", 1'b0, driverHiZ);
        t_regs();
        t_lock();
        t_ov();
        t_uv();
        chk_bit("overlapSeen", 1'b0, overlapSeen);
        tally_and_finish();
    end
endmodule

bind grfp_top grfp_chk chk_u (.sys_clk(sys_clk), .rst(rst), .gfxOutputSenseNeg(gfxOutputSenseNeg),
    .gfxOffsetSetInput(gfxOffsetSetInput), .controllerSupplyOk(controllerSupplyOk),
    .driverSupplySense(driverSupplySense), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .highSideOn(highSideOn), .lowSideOn(lowSideOn), .driverHiZ(driverHiZ),
    .coreRailShutdown(coreRailShutdown), .wb_ack_o(wb_ack_o));
